/* core/lax_pkg.sv */
// lax_pkg: constants and carrier types of the axis command decoder
// assumes one 100 MHz clock and a drive stage that reports position
//
// Functional notes
// - two modes, monostable one and bistable two
// - mode one after reset or unconfigured
// - omnistable stroke may halt anywhere
// - omnistable all low: stop and hold
// - omnistable: retract or extend per input
// - teach plus retract: learn, retract first
// - teach plus extend: learn, extend first
// - teach alone: powerless, ready, clear errors
// - omnistable third input: teach, reset, powerless
// - retracted variant: extend high, else retract
// - retracted variant teach: learn, retract first
// - retracted variant ignores the retract input
package lax_pkg;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_MHZ      = 100;
	localparam int MODE_WIN_US  = 1000;
	localparam int MODE_WIN_CYC = MODE_WIN_US * CLK_MHZ;

	// ************************************************
	// register map and fields
	// ************************************************
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_IRQ   = 8'h08;
	localparam logic [7:0] A_MASK  = 8'h0c;
	localparam logic [7:0] A_INNER = 8'h10;
	localparam logic [7:0] A_OUTER = 8'h14;
	localparam int CTRL_VARIANT = 0;
	localparam logic CTRL_VARIANT_RST = 1'b0;
	localparam int STAT_MODE    = 2;
	localparam int STAT_LEARNED = 3;
	localparam int STAT_FAULT   = 4;
	localparam int IRQ_LEARN = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_UNDEF = 2;
	localparam int IRQ_MODE  = 3;
	localparam int IRQ_W     = 4;
	localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
	localparam int POS_W = 16;

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [2:0] {
		CMD_HOLD    = 3'b000,
		CMD_EXTEND  = 3'b001,
		CMD_RETRACT = 3'b010,
		CMD_LEARN   = 3'b011,
		CMD_OFF     = 3'b100
	} lax_cmd_t;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_LEARN_A = 2'b01,
		ST_LEARN_B = 2'b10,
		ST_OFF     = 2'b11
	} lax_state_t;

	typedef enum logic {
		MODE_MONO = 1'b0,
		MODE_BI   = 1'b1
	} lax_mode_t;

	typedef struct packed {
		lax_cmd_t cmd;
		logic     slow;
		logic     toward_outer;
		logic     clear_err;
	} lax_drive_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} lax_bus_t;

	typedef struct packed {
		logic [POS_W-1:0] pos;
		logic             at_stop;
		logic             still;
		logic             fault;
	} lax_fb_t;
endpackage

/* core/lax_sync.sv */
// lax_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ns
module lax_sync
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic [2:0] ff;
		logic       lvl;
	} lax_sync_st_t;

	lax_sync_st_t s_r;
	lax_sync_st_t s_nxt;

	// stage 0 feeds stage 1 only; a change counts once 1 and 2 agree
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ff = {s_r.ff[1:0], pin};
		if (s_r.ff[1] == s_r.ff[2])
			s_nxt.lvl = s_r.ff[2];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign level = s_r.lvl;
endmodule

/* core/lax_decoder.sv */
// lax_decoder: decodes the controller's command pins into drive commands
// assumes a drive stage on clk that reports position, end stop and fault
`timescale 1ns/1ns
module lax_decoder
#(
	parameter int MODE_WIN_CYC = lax_pkg::MODE_WIN_CYC
)
(
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              extend_request_in,
	input  wire logic              retract_request_in,
	input  wire logic              learn_reset_request_in,
	input  wire lax_pkg::lax_fb_t  fb,
	input  wire lax_pkg::lax_bus_t bus,
	output logic [31:0]            rdata,
	output lax_pkg::lax_drive_t    drive,
	output logic                   ready,
	output logic                   at_outer_stop_out,
	output logic                   at_inner_stop_out,
	output logic                   irq
);
	localparam int WIN_W = $clog2(MODE_WIN_CYC + 1);
	localparam logic [WIN_W-1:0] WIN_RST = WIN_W'(MODE_WIN_CYC);

	if (MODE_WIN_CYC < 1 || WIN_W > 31)
	begin : g_bad_win
		$error("MODE_WIN_CYC out of range");
	end

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		lax_pkg::lax_state_t      st;
		lax_pkg::lax_mode_t       mode;
		logic                     mode_done;
		logic [WIN_W-1:0]         win;
		logic                     variant;
		lax_pkg::lax_cmd_t        bist;
		logic                     learn_outer;
		logic                     learned;
		logic                     fault;
		logic                     fault_d;
		logic [lax_pkg::POS_W-1:0] inner;
		logic [lax_pkg::POS_W-1:0] outer;
		logic [lax_pkg::IRQ_W-1:0] irq;
		logic [lax_pkg::IRQ_W-1:0] mask;
		lax_pkg::lax_drive_t      drive;
		logic                     ready;
		logic                     at_outer;
		logic                     at_inner;
		logic [31:0]              rdata;
	} lax_core_st_t;

	lax_core_st_t s_r;
	lax_core_st_t s_nxt;

	logic e;
	logic r;
	logic t;

	// ************************************************
	// pin synchronisers
	// ************************************************
	lax_sync u_sync_ext (.clk(clk), .nrst(nrst), .pin(extend_request_in), .level(e));
	lax_sync u_sync_ret (.clk(clk), .nrst(nrst), .pin(retract_request_in), .level(r));
	lax_sync u_sync_learn (.clk(clk), .nrst(nrst), .pin(learn_reset_request_in), .level(t));

	// ************************************************
	// command decode
	// ************************************************
	lax_pkg::lax_cmd_t run_cmd;
	logic              go_learn;
	logic              learn_out;
	logic              go_off;
	logic              undef;

	always_comb
	begin
		run_cmd = lax_pkg::CMD_HOLD;
		go_learn = 1'b0;
		learn_out = 1'b0;
		go_off = 1'b0;
		undef = 1'b0;
		if (s_r.mode == lax_pkg::MODE_BI)
		begin
			// bistable: a run command latches until the counter signal
			case ({e, r, t})
				3'b100: run_cmd = lax_pkg::CMD_EXTEND;
				3'b010: run_cmd = lax_pkg::CMD_RETRACT;
				3'b110: run_cmd = lax_pkg::CMD_HOLD;
				3'b000: run_cmd = s_r.bist;
				3'b001: go_off = 1'b1;
				3'b101:
				begin
					go_learn = 1'b1;
					learn_out = 1'b1;
				end
				3'b011: go_learn = 1'b1;
				default: undef = 1'b1;
			endcase
		end
		else if (s_r.variant)
		begin
			// retract pin has no meaning in this variant
			case ({e, t})
				2'b10: run_cmd = lax_pkg::CMD_EXTEND;
				2'b00: run_cmd = lax_pkg::CMD_RETRACT;
				2'b01: go_learn = 1'b1;
				default: undef = 1'b1;
			endcase
		end
		else
		begin
			// third pin meaning picked by the motion pins
			case ({e, r, t})
				3'b000: run_cmd = lax_pkg::CMD_HOLD;
				3'b010: run_cmd = lax_pkg::CMD_RETRACT;
				3'b100: run_cmd = lax_pkg::CMD_EXTEND;
				3'b011: go_learn = 1'b1;
				3'b101:
				begin
					go_learn = 1'b1;
					learn_out = 1'b1;
				end
				3'b001: go_off = 1'b1;
				// hold rather than guess a direction
				default: undef = 1'b1;
			endcase
		end
	end

	// ************************************************
	// next state
	// ************************************************
	logic [lax_pkg::IRQ_W-1:0] ev;
	logic [lax_pkg::IRQ_W-1:0] clr;
	logic                      leg_outer;

	always_comb
	begin
		s_nxt = s_r;
		ev = '0;
		clr = '0;
		leg_outer = 1'b0;
		s_nxt.drive.clear_err = 1'b0;

		// power-up window for the three-pin mode change
		if (s_r.win != '0)
		begin
			s_nxt.win = s_r.win - WIN_W'(1);
			if (e && r && t && !s_r.mode_done)
			begin
				s_nxt.mode = (s_r.mode == lax_pkg::MODE_MONO) ? lax_pkg::MODE_BI
					: lax_pkg::MODE_MONO;
				s_nxt.mode_done = 1'b1;
				ev[lax_pkg::IRQ_MODE] = 1'b1;
			end
		end

		if (undef && s_r.st == lax_pkg::ST_RUN)
			ev[lax_pkg::IRQ_UNDEF] = 1'b1;

		case (s_r.st)
			lax_pkg::ST_RUN:
			begin
				if (go_off)
				begin
					s_nxt.st = lax_pkg::ST_OFF;
					s_nxt.drive.clear_err = 1'b1;
					s_nxt.bist = lax_pkg::CMD_HOLD;
				end
				else if (go_learn)
				begin
					s_nxt.st = lax_pkg::ST_LEARN_A;
					s_nxt.learn_outer = learn_out;
				end
				else
					s_nxt.bist = run_cmd;
			end
			lax_pkg::ST_LEARN_A,
			lax_pkg::ST_LEARN_B:
			begin
				leg_outer = (s_r.st == lax_pkg::ST_LEARN_A) ? s_r.learn_outer : !s_r.learn_outer;
				if (go_off)
				begin
					s_nxt.st = lax_pkg::ST_OFF;
					s_nxt.drive.clear_err = 1'b1;
				end
				else if (fb.at_stop)
				begin
					// each leg ends on a stop and stores it
					if (leg_outer)
						s_nxt.outer = fb.pos;
					else
						s_nxt.inner = fb.pos;
					if (s_r.st == lax_pkg::ST_LEARN_A)
						s_nxt.st = lax_pkg::ST_LEARN_B;
					else
					begin
						s_nxt.st = lax_pkg::ST_RUN;
						s_nxt.learned = 1'b1;
						ev[lax_pkg::IRQ_LEARN] = 1'b1;
					end
				end
				s_nxt.bist = lax_pkg::CMD_HOLD;
			end
			lax_pkg::ST_OFF:
			begin
				if (!go_off)
					s_nxt.st = lax_pkg::ST_RUN;
			end
			default: s_nxt.st = lax_pkg::ST_RUN;
		endcase

		// drive command follows the state being entered
		s_nxt.drive.slow = 1'b0;
		s_nxt.drive.toward_outer = 1'b0;
		case (s_nxt.st)
			lax_pkg::ST_RUN:
			begin
				s_nxt.drive.cmd = run_cmd;
				s_nxt.drive.toward_outer = (run_cmd == lax_pkg::CMD_EXTEND);
			end
			lax_pkg::ST_LEARN_A:
			begin
				s_nxt.drive.cmd = lax_pkg::CMD_LEARN;
				s_nxt.drive.slow = 1'b1;
				s_nxt.drive.toward_outer = s_nxt.learn_outer;
			end
			lax_pkg::ST_LEARN_B:
			begin
				s_nxt.drive.cmd = lax_pkg::CMD_LEARN;
				s_nxt.drive.slow = 1'b1;
				s_nxt.drive.toward_outer = !s_nxt.learn_outer;
			end
			lax_pkg::ST_OFF: s_nxt.drive.cmd = lax_pkg::CMD_OFF;
			default: s_nxt.drive.cmd = lax_pkg::CMD_HOLD;
		endcase

		// fault latch: a new fault wins over the clear
		s_nxt.fault_d = fb.fault;
		if (fb.fault && !s_r.fault_d)
			ev[lax_pkg::IRQ_FAULT] = 1'b1;
		s_nxt.fault = (s_r.fault && !s_nxt.drive.clear_err) || fb.fault;

		// stays ready while powerless; only a fault withdraws it
		s_nxt.ready = !s_nxt.fault;
		s_nxt.at_outer = s_nxt.ready && s_r.learned && fb.still
			&& s_nxt.st == lax_pkg::ST_RUN && fb.pos == s_r.outer;
		s_nxt.at_inner = s_nxt.ready && s_r.learned && fb.still
			&& s_nxt.st == lax_pkg::ST_RUN && fb.pos == s_r.inner;

		// ************************************************
		// register port
		// ************************************************
		if (bus.we)
		begin
			case (bus.addr)
				lax_pkg::A_CTRL: s_nxt.variant = bus.wdata[lax_pkg::CTRL_VARIANT];
				lax_pkg::A_MASK: s_nxt.mask = bus.wdata[lax_pkg::IRQ_W-1:0];
				lax_pkg::A_IRQ: clr = bus.wdata[lax_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
		// an event in the clearing cycle is kept
		s_nxt.irq = (s_r.irq & ~clr) | ev;

		s_nxt.rdata = '0;
		if (bus.re)
		begin
			case (bus.addr)
				lax_pkg::A_CTRL: s_nxt.rdata[lax_pkg::CTRL_VARIANT] = s_r.variant;
				lax_pkg::A_STAT:
				begin
					s_nxt.rdata[1:0] = s_r.st;
					s_nxt.rdata[lax_pkg::STAT_MODE] = s_r.mode;
					s_nxt.rdata[lax_pkg::STAT_LEARNED] = s_r.learned;
					s_nxt.rdata[lax_pkg::STAT_FAULT] = s_r.fault;
				end
				lax_pkg::A_IRQ: s_nxt.rdata[lax_pkg::IRQ_W-1:0] = s_r.irq;
				lax_pkg::A_MASK: s_nxt.rdata[lax_pkg::IRQ_W-1:0] = s_r.mask;
				lax_pkg::A_INNER: s_nxt.rdata[lax_pkg::POS_W-1:0] = s_r.inner;
				lax_pkg::A_OUTER: s_nxt.rdata[lax_pkg::POS_W-1:0] = s_r.outer;
				default: s_nxt.rdata = '0;
			endcase
		end
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r <= '0;
			s_r.st <= lax_pkg::ST_RUN;
			s_r.mode <= lax_pkg::MODE_MONO;
			s_r.win <= WIN_RST;
			s_r.variant <= lax_pkg::CTRL_VARIANT_RST;
			s_r.bist <= lax_pkg::CMD_HOLD;
			s_r.mask <= lax_pkg::MASK_RST;
			s_r.ready <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
	assign drive = s_r.drive;
	assign ready = s_r.ready;
	assign at_outer_stop_out = s_r.at_outer;
	assign at_inner_stop_out = s_r.at_inner;
	assign irq = |(s_r.irq & s_r.mask);

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	logic omni_run;
	logic mono_run;
	assign omni_run = s_r.st == lax_pkg::ST_RUN && s_r.mode == lax_pkg::MODE_MONO && !s_r.variant;
	assign mono_run = s_r.st == lax_pkg::ST_RUN && s_r.mode == lax_pkg::MODE_MONO && s_r.variant;

	chk_mode_default: assert property (
		!s_r.mode_done |-> s_r.mode == lax_pkg::MODE_MONO)
		else $error("mode left mode one without the power-up sequence");
	chk_mode_window: assert property (
		s_r.mode != $past(s_r.mode) |-> $past(s_r.win) != '0 && s_r.mode_done)
		else $error("mode changed outside the power-up window");
	chk_omni_hold: assert property (
		omni_run && {e, r, t} == 3'b000 |=> drive.cmd == lax_pkg::CMD_HOLD)
		else $error("omnistable idle did not hold");
	chk_omni_retract: assert property (
		omni_run && {e, r, t} == 3'b010 |=> drive.cmd == lax_pkg::CMD_RETRACT && !drive.toward_outer)
		else $error("omnistable retract not issued");
	chk_omni_extend: assert property (
		omni_run && {e, r, t} == 3'b100 |=> drive.cmd == lax_pkg::CMD_EXTEND && drive.toward_outer)
		else $error("omnistable extend not issued");
	chk_learn_inner: assert property (omni_run && {e, r, t} == 3'b011
		|=> s_r.st == lax_pkg::ST_LEARN_A && drive.slow && !drive.toward_outer)
		else $error("learn run did not start retracting");
	chk_learn_outer: assert property (omni_run && {e, r, t} == 3'b101
		|=> s_r.st == lax_pkg::ST_LEARN_A && drive.slow && drive.toward_outer)
		else $error("learn run did not start extending");
	chk_off_ready: assert property (omni_run && {e, r, t} == 3'b001 && !fb.fault
		|=> drive.cmd == lax_pkg::CMD_OFF && drive.clear_err && ready)
		else $error("powerless request mishandled");
	chk_mono_extend: assert property (
		mono_run && e && !t |=> drive.cmd == lax_pkg::CMD_EXTEND)
		else $error("retracted variant did not extend");
	chk_mono_rest: assert property (
		mono_run && !e && !t |=> drive.cmd == lax_pkg::CMD_RETRACT)
		else $error("retracted variant did not return to rest");
	chk_mono_learn: assert property (
		mono_run && !e && t |=> s_r.st == lax_pkg::ST_LEARN_A && !drive.toward_outer)
		else $error("retracted variant learn run wrong");
	chk_stop_flags: assert property (
		at_outer_stop_out || at_inner_stop_out |-> ready && $past(fb.still) && s_r.learned)
		else $error("end-stop flag without rest at a taught end");
endmodule

/* verif/lax_drive_model.sv */
// lax_drive_model: behavioural drive stage answering the decoder's commands
// assumes lax_pkg and the decoder's clock; travel limits are bench choices
`timescale 1ns/1ns
module lax_drive_model
#(
	parameter logic [15:0] P_IN  = 16'h0010,
	parameter logic [15:0] P_OUT = 16'h0050
)
(
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire lax_pkg::lax_drive_t drive,
	input  wire logic                fault_in,
	output lax_pkg::lax_fb_t         fb
);
	// ********
	// slide motion
	// ********
	logic [15:0] pos_r;
	logic        up;
	logic        dn;
	logic        lrn;

	always_comb
	begin
		lrn = drive.cmd == lax_pkg::CMD_LEARN;
		up = (drive.cmd == lax_pkg::CMD_EXTEND || (lrn && drive.toward_outer)) && pos_r < P_OUT;
		dn = (drive.cmd == lax_pkg::CMD_RETRACT || (lrn && !drive.toward_outer)) && pos_r > P_IN;
		fb.pos = pos_r;
		fb.still = !(up || dn);
		// learn run blocked only by a mechanical stop
		fb.at_stop = lrn && !up && !dn;
		fb.fault = fault_in;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pos_r <= 16'h0030;
		else if (up)
			pos_r <= pos_r + 16'h0001;
		else if (dn)
			pos_r <= pos_r - 16'h0001;
	end
endmodule

/* verif/tb.sv */
// tb: self-checking bench for lax_decoder beside a behavioural drive stage
// assumes lax_pkg, lax_decoder and lax_drive_model; short mode window
`timescale 1ns/1ns
module tb;
	logic                clk;
	logic                nrst;
	logic                ext;
	logic                rtr;
	logic                lrn;
	logic                flt;
	lax_pkg::lax_bus_t   bus;
	lax_pkg::lax_fb_t    fb;
	lax_pkg::lax_drive_t drive;
	logic [31:0]         rdata;
	logic                ready;
	logic                at_out;
	logic                at_in;
	logic                irq;
	logic [63:0]         rq[$];
	logic                re_d;
	int                  bad_count;
	int                  n_tests;
	int                  cyc;
	int                  k;
	integer              seed;
	logic [2:0]          opin[4];
	lax_pkg::lax_cmd_t   ocmd[4];

	lax_decoder #(.MODE_WIN_CYC(16)) u_dut (.clk(clk), .nrst(nrst), .extend_request_in(ext),
		.retract_request_in(rtr), .learn_reset_request_in(lrn), .fb(fb), .bus(bus), .rdata(rdata),
		.drive(drive), .ready(ready), .at_outer_stop_out(at_out), .at_inner_stop_out(at_in),
		.irq(irq));
	lax_drive_model u_drv (.clk(clk), .nrst(nrst), .drive(drive), .fault_in(flt), .fb(fb));

	always #5 clk = ~clk;

	// ********
	// tasks
	// ********
	task automatic report_and_stop;
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic bad(input string m);
		bad_count++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
			bad($sformatf("flag %b exp %b", got, exp));
	endtask

	// bounded wait covers the pin synchroniser latency
	task automatic chk_cmd(input lax_pkg::lax_cmd_t exp);
		for (int i = 0; i < 12 && drive.cmd !== exp; i++)
			@(posedge clk);
		n_tests++;
		if (drive.cmd !== exp)
			bad($sformatf("cmd %h exp %h", drive.cmd, exp));
	endtask

	task automatic learn_end;
		for (int i = 0; i < 400 && drive.cmd === lax_pkg::CMD_LEARN; i++)
			@(posedge clk);
	endtask

	task automatic pins(input logic [2:0] p);
		@(posedge clk);
		{ext, rtr, lrn} <= p;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		rq.push_back({m, e});
		@(posedge clk);
		bus.re <= 1'b0;
	endtask

	task automatic do_reset(input logic [2:0] p);
		nrst <= 1'b0;
		{ext, rtr, lrn} <= p;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
	endtask

	// ********
	// read monitor and hang guard
	// ********
	always @(posedge clk)
	begin
		re_d <= bus.re;
		cyc <= cyc + 1;
		if (re_d)
		begin
			n_tests++;
			if ((rdata & rq[0][63:32]) !== rq[0][31:0])
				bad($sformatf("rdata %h exp %h", rdata, rq[0][31:0]));
			void'(rq.pop_front());
		end
		if (cyc == 20000)
		begin
			bad("timeout");
			report_and_stop();
		end
	end

	initial
	begin
		clk = 1'b0;
		{ext, rtr, lrn} = 3'h0;
		flt = 1'b0;
		bus = '0;
		re_d = 1'b0;
		seed = 32'h1be7;
		opin = '{3'h0, 3'h2, 3'h4, 3'h1};
		ocmd = '{lax_pkg::CMD_HOLD, lax_pkg::CMD_RETRACT, lax_pkg::CMD_EXTEND, lax_pkg::CMD_OFF};
		do_reset(3'h0);
		chk_bit(ready, 1'b1);
		rd(lax_pkg::A_CTRL, 32'hffffffff, 32'h0);
		rd(lax_pkg::A_STAT, 32'h4, 32'h0);
		rd(lax_pkg::A_MASK, 32'hf, 32'h0);
		rd(8'h3c, 32'hffffffff, 32'h0);
		wr(lax_pkg::A_STAT, 32'h1f);
		rd(lax_pkg::A_STAT, 32'h1f, 32'h0);
		// controller never raises extend with retract here
		for (int i = 0; i < 16; i++)
		begin
			k = {$random(seed)} % 4;
			pins(opin[k]);
			chk_cmd(ocmd[k]);
		end
		for (int i = 6; i < 8; i++)
		begin
			pins(3'h4);
			chk_cmd(lax_pkg::CMD_EXTEND);
			pins(i[2:0]);
			chk_cmd(lax_pkg::CMD_HOLD);
		end
		rd(lax_pkg::A_IRQ, 32'h4, 32'h4);
		@(posedge clk);
		flt <= 1'b1;
		repeat (3) @(posedge clk);
		chk_bit(ready, 1'b0);
		flt <= 1'b0;
		rd(lax_pkg::A_STAT, 32'h10, 32'h10);
		pins(3'h1);
		chk_cmd(lax_pkg::CMD_OFF);
		chk_bit(drive.clear_err, 1'b1);
		repeat (3) @(posedge clk);
		chk_bit(ready, 1'b1);
		chk_bit(drive.clear_err, 1'b0);
		rd(lax_pkg::A_STAT, 32'h10, 32'h0);
		pins(3'h3);
		chk_cmd(lax_pkg::CMD_LEARN);
		chk_bit(drive.toward_outer, 1'b0);
		chk_bit(drive.slow, 1'b1);
		pins(3'h0);
		learn_end();
		chk_cmd(lax_pkg::CMD_HOLD);
		rd(lax_pkg::A_INNER, 32'hffff, 32'h10);
		rd(lax_pkg::A_OUTER, 32'hffff, 32'h50);
		chk_bit(at_out, 1'b1);
		chk_bit(at_in, 1'b0);
		rd(lax_pkg::A_IRQ, 32'h1, 32'h1);
		wr(lax_pkg::A_MASK, 32'h1);
		@(posedge clk);
		chk_bit(irq, 1'b1);
		wr(lax_pkg::A_IRQ, 32'hf);
		@(posedge clk);
		chk_bit(irq, 1'b0);
		pins(3'h5);
		chk_cmd(lax_pkg::CMD_LEARN);
		chk_bit(drive.toward_outer, 1'b1);
		pins(3'h0);
		learn_end();
		chk_cmd(lax_pkg::CMD_HOLD);
		chk_bit(at_in, 1'b1);
		wr(lax_pkg::A_CTRL, 32'h1);
		pins(3'h4);
		chk_cmd(lax_pkg::CMD_EXTEND);
		pins(3'h6);
		repeat (6) @(posedge clk);
		chk_cmd(lax_pkg::CMD_EXTEND);
		pins(3'h2);
		chk_cmd(lax_pkg::CMD_RETRACT);
		pins(3'h1);
		chk_cmd(lax_pkg::CMD_LEARN);
		chk_bit(drive.toward_outer, 1'b0);
		pins(3'h0);
		learn_end();
		chk_cmd(lax_pkg::CMD_RETRACT);
		pins(3'h5);
		chk_cmd(lax_pkg::CMD_HOLD);
		// all three pins at power-up request the other mode
		do_reset(3'h7);
		repeat (8) @(posedge clk);
		pins(3'h0);
		rd(lax_pkg::A_STAT, 32'h4, 32'h4);
		rd(lax_pkg::A_IRQ, 32'h8, 32'h8);
		pins(3'h4);
		chk_cmd(lax_pkg::CMD_EXTEND);
		pins(3'h0);
		repeat (6) @(posedge clk);
		chk_cmd(lax_pkg::CMD_EXTEND);
		pins(3'h2);
		chk_cmd(lax_pkg::CMD_RETRACT);
		pins(3'h0);
		repeat (6) @(posedge clk);
		chk_cmd(lax_pkg::CMD_RETRACT);
		repeat (2) @(posedge clk);
		report_and_stop();
	end
endmodule
